// ### rtl/accum_alu_params.svh
// Offsets, reset values, SFR addresses, opcodes and cycle figures.
// Included by the decoder package users; holds definitions only.
`ifndef ACCUM_ALU_PARAMS_SVH
`define ACCUM_ALU_PARAMS_SVH
`define REG_CTRL 8'h00
`define REG_INSTR 8'h04
`define REG_STAT 8'h08
`define REG_ACCB 8'h0C
`define REG_PCDP 8'h10
`define REG_RAMA 8'h14
`define REG_RAMD 8'h18
`define REG_BITQ 8'h1C
`define REG_FETCH 8'h20
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`define SP_RST 8'h07
`define SFR_BASE 8'h80
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
`define SFR_PSW 8'hD0
`define SFR_ACC 8'hE0
`define SFR_B 8'hF0
`define BIT_RAM_BASE 8'h20
`define BCD_MAX 4'h9
`define OP_SHORT_BRANCH 8'h80
`define OP_FAR_JUMP 8'h02
`define OP_FAR_CALL 8'h12
`define OP_INCDP 8'hA3
`define OP_MUL 8'hA4
`define OP_DIV 8'h84
`define OP_DA 8'hD4
`define OP_CLR 8'hE4
`define OP_CPL 8'hF4
`define OP_MOVC_PC 8'h83
`define OP_MOVC_DP 8'h93
`define GRP_INC 4'h0
`define GRP_DEC 4'h1
`define GRP_ADD 4'h2
`define GRP_ADD_WITH_CARRY 4'h3
`define GRP_ORL 4'h4
`define GRP_ANL 4'h5
`define GRP_XRL 4'h6
`define GRP_SUBTRACT_WITH_BORROW 4'h9
`define CYC_MULDIV 4'h5
`define CYC_LONG 4'h3
`define CYC_JMP 4'h3
`define CYC_FAR 4'h4
`define CLKS_PER_ICYC 4
`endif

// ### rtl/accum_alu_pkg.sv
// Types shared by the accumulator decode block.
// Assumes the params header is compiled alongside.
package accum_alu_pkg;
  typedef enum {ST_IDLE, ST_RUN} core_state_type;
  typedef enum {K_ILL, K_ADD, K_ADD_WITH_CARRY, K_SUBTRACT_WITH_BORROW, K_AND, K_OR, K_XOR, K_INC,
    K_DEC, K_MUL, K_DIV, K_DA, K_CLR, K_CPL, K_INCDP, K_SHORT_BRANCH, K_PAGE_JUMP,
    K_PAGE_CALL, K_FAR_JUMP, K_FAR_CALL, K_MOVC} op_kind_type;
  typedef enum {M_ACC, M_IMM, M_DIR, M_IND, M_REG} op_mode_type;
endpackage : accum_alu_pkg

// ### rtl/accum_alu_instr_decode.sv
// Accumulator core decode/execute for arithmetic, logic and branches.
// Assumes an AXI4-Lite master on mclk; internal RAM lives here.
// Functional notes
// RL1 - Rn indexes bank chosen by status bits
// RL2 - Direct below 0x80 RAM, else SFRs
// RL3 - Indirect via R0/R1 reaches all RAM
// RL4 - Short branch: signed byte from next PC
// RL5 - Bit addresses map RAM 20-2F, SFR x0/x8
// RL6 - Page jump/call keeps upper five PC bits
// RL7 - Far jump/call takes full 16 bits
// RL8 - Page forms and code read use next PC
// RL9 - Flags behave like standard architecture
// RL10 - Cycle counts per opcode, scaled clocks
// RL11 - Add opcodes, lengths, carry/excess/aux flags
// RL12 - Add with carry, same forms and flags
// RL13 - Subtract with borrow, flags updated
// RL14 - Multiply A4, five cycles, carry cleared
// RL15 - Divide 84, five cycles, carry cleared
// RL16 - And group, direct targets, no flags
// RL17 - Or group, direct targets, no flags
// RL18 - Xor group, direct targets, no flags
// RL19 - Inc/dec keep flags; pointer inc three
// RL20 - Decimal adjust sets carry; clear/complement
`include "accum_alu_params.svh"
module accum_alu_instr_decode #(
  parameter int ADDR_W = 8,
  parameter int CLKS_PER_ICYC = `CLKS_PER_ICYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] ram [0:255];
  accum_alu_pkg::core_state_type st_q, st_d;
  accum_alu_pkg::op_kind_type kind;
  accum_alu_pkg::op_mode_type mode;
  logic [23:0] instr_q, instr_d;
  logic [7:0] acc_q, acc_d, b_q, b_d, psw_q, psw_d, sp_q, sp_d;
  logic [7:0] rama_q, rama_d, bitq_q, bitq_d;
  logic [15:0] pc_q, pc_d, data_pointer_16_q, data_pointer_16_d, fetch_q, fetch_d;
  logic [15:0] cnt_q, cnt_d;
  logic done_q, done_d, ill_q, ill_d;
  logic [3:0] cyc_last_q, cyc_last_d, cyc;
  logic [1:0] len_last_q, len_last_d, len;
  logic [7:0] op, op1, op2, psw_rd, reg_a, ri, src, dir_v, a_in, b_in;
  logic [7:0] res, bm_byte;
  logic [3:0] hi, lo;
  logic to_dir, commit, busy;
  logic [15:0] pc_next, prod;
  logic [8:0] s9, da9;
  logic [4:0] n5;
  logic ga_en, gb_en;
  logic [7:0] ga_addr, ga_data, gb_addr, gb_data;
  logic gw_en, gw_sfr;
  logic [7:0] gw_addr, gw_data;
  // Bus side
  logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [ADDR_W-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic wr_go, wr_ok;
  logic [7:0] wr_a;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction : merge

  function automatic logic reg_hit(input logic [7:0] a);
    return a == `REG_CTRL || a == `REG_INSTR || a == `REG_STAT ||
      a == `REG_ACCB || a == `REG_PCDP || a == `REG_RAMA ||
      a == `REG_RAMD || a == `REG_BITQ || a == `REG_FETCH;
  endfunction : reg_hit

  assign op = instr_q[7:0];
  assign op1 = instr_q[15:8];
  assign op2 = instr_q[23:16];
  assign hi = op[7:4];
  assign lo = op[3:0];
  assign busy = st_q == accum_alu_pkg::ST_RUN;
  assign commit = busy && cnt_q == 16'h0001;
  // Parity bit always tracks the accumulator
  assign psw_rd = {psw_q[7:1], ^acc_q}; // [RL9]
  assign reg_a = {3'b000, psw_q[4:3], op[2:0]}; // [RL1]
  assign ri = ram[{3'b000, psw_q[4:3], 2'b00, op[0]}]; // [RL1]
  assign pc_next = pc_q + {14'h0000, len}; // [RL8]
  // Bit address map for the query register
  assign bm_byte = bitq_q[7] ? {bitq_q[7:3], 3'b000} :
    `BIT_RAM_BASE + {4'h0, bitq_q[6:3]}; // [RL5]

  always_comb begin
    dir_v = ram[op1];
    if (op1 >= `SFR_BASE) begin // [RL2]
      case (op1)
        `SFR_ACC: dir_v = acc_q;
        `SFR_B: dir_v = b_q;
        `SFR_PSW: dir_v = psw_rd;
        `SFR_SP: dir_v = sp_q;
        `SFR_DPL: dir_v = data_pointer_16_q[7:0];
        `SFR_DPH: dir_v = data_pointer_16_q[15:8];
        default: dir_v = 8'h00;
      endcase
    end
  end

  // Opcode decode: kind, operand mode, length and cycles
  always_comb begin
    kind = accum_alu_pkg::K_ILL;
    mode = accum_alu_pkg::M_ACC;
    to_dir = 1'b0;
    len = 2'd1;
    cyc = 4'h1;
    if (lo == 4'h1) begin
      kind = hi[0] ? accum_alu_pkg::K_PAGE_CALL : accum_alu_pkg::K_PAGE_JUMP;
      len = 2'd2;
      cyc = `CYC_JMP;
    end else if (lo >= 4'h4 && (hi <= `GRP_XRL || hi == `GRP_SUBTRACT_WITH_BORROW)) begin
      case (lo)
        4'h4: mode = accum_alu_pkg::M_IMM;
        4'h5: mode = accum_alu_pkg::M_DIR;
        4'h6, 4'h7: mode = accum_alu_pkg::M_IND; // [RL3]
        default: mode = accum_alu_pkg::M_REG;
      endcase
      len = (lo == 4'h4 || lo == 4'h5) ? 2'd2 : 2'd1; // [RL10]
      case (hi)
        `GRP_INC: kind = accum_alu_pkg::K_INC; // [RL19]
        `GRP_DEC: kind = accum_alu_pkg::K_DEC; // [RL19]
        `GRP_ADD: kind = accum_alu_pkg::K_ADD; // [RL11]
        `GRP_ADD_WITH_CARRY: kind = accum_alu_pkg::K_ADD_WITH_CARRY; // [RL12]
        `GRP_ORL: kind = accum_alu_pkg::K_OR; // [RL17]
        `GRP_ANL: kind = accum_alu_pkg::K_AND; // [RL16]
        `GRP_XRL: kind = accum_alu_pkg::K_XOR; // [RL18]
        default: kind = accum_alu_pkg::K_SUBTRACT_WITH_BORROW; // [RL13]
      endcase
      if (lo == 4'h4 && hi <= `GRP_DEC) begin
        mode = accum_alu_pkg::M_ACC;
        len = 2'd1;
      end
      cyc = {2'b00, len};
    end else if ((lo == 4'h2 || lo == 4'h3) && hi >= `GRP_ORL &&
        hi <= `GRP_XRL) begin
      kind = hi == `GRP_ORL ? accum_alu_pkg::K_OR :
        hi == `GRP_ANL ? accum_alu_pkg::K_AND : accum_alu_pkg::K_XOR;
      to_dir = 1'b1; // [RL16] [RL17] [RL18]
      mode = lo[0] ? accum_alu_pkg::M_IMM : accum_alu_pkg::M_ACC;
      len = lo[0] ? 2'd3 : 2'd2;
      cyc = {2'b00, len};
    end else begin
      case (op)
        `OP_SHORT_BRANCH: begin
          kind = accum_alu_pkg::K_SHORT_BRANCH;
          len = 2'd2;
          cyc = `CYC_JMP;
        end
        `OP_FAR_JUMP, `OP_FAR_CALL: begin
          kind = op[4] ? accum_alu_pkg::K_FAR_CALL : accum_alu_pkg::K_FAR_JUMP;
          len = 2'd3;
          cyc = `CYC_FAR;
        end
        `OP_INCDP: begin
          kind = accum_alu_pkg::K_INCDP;
          cyc = `CYC_LONG; // [RL19]
        end
        `OP_MUL, `OP_DIV: begin
          kind = op[5] ? accum_alu_pkg::K_MUL : accum_alu_pkg::K_DIV;
          cyc = `CYC_MULDIV; // [RL14] [RL15]
        end
        `OP_MOVC_PC, `OP_MOVC_DP: begin
          kind = accum_alu_pkg::K_MOVC;
          cyc = `CYC_LONG;
        end
        `OP_DA: kind = accum_alu_pkg::K_DA;
        `OP_CLR: kind = accum_alu_pkg::K_CLR; // [RL20]
        `OP_CPL: kind = accum_alu_pkg::K_CPL; // [RL20]
        default: kind = accum_alu_pkg::K_ILL;
      endcase
    end
  end

  always_comb begin
    case (mode)
      accum_alu_pkg::M_IMM: src = to_dir ? op2 : op1;
      accum_alu_pkg::M_DIR: src = dir_v;
      accum_alu_pkg::M_IND: src = ram[ri]; // [RL3]
      accum_alu_pkg::M_REG: src = ram[reg_a];
      default: src = acc_q;
    endcase
    a_in = to_dir ? dir_v : acc_q;
    b_in = src;
  end

  // Execute and state update; results land on the final clock
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    instr_d = instr_q;
    acc_d = acc_q;
    b_d = b_q;
    psw_d = psw_q;
    sp_d = sp_q;
    pc_d = pc_q;
    data_pointer_16_d = data_pointer_16_q;
    fetch_d = fetch_q;
    rama_d = rama_q;
    bitq_d = bitq_q;
    done_d = done_q;
    ill_d = ill_q;
    cyc_last_d = cyc_last_q;
    len_last_d = len_last_q;
    gw_en = 1'b0;
    gw_sfr = 1'b0;
    gw_addr = 8'h00;
    gw_data = 8'h00;
    gb_en = 1'b0;
    gb_addr = 8'h00;
    gb_data = 8'h00;
    s9 = 9'h000;
    n5 = 5'h00;
    da9 = 9'h000;
    prod = acc_q * b_q;
    res = 8'h00;
    if (wr_go && wr_ok) begin
      case (wr_a)
        `REG_CTRL: if (wr_strb[0] && wr_data[0]) begin
          st_d = accum_alu_pkg::ST_RUN;
          cnt_d = 16'(cyc * CLKS_PER_ICYC); // [RL10]
        end
        `REG_INSTR: instr_d = 24'(merge({8'h00, instr_q}, wr_data,
          wr_strb));
        `REG_STAT: if (wr_strb[0] && wr_data[1]) done_d = 1'b0;
        `REG_ACCB: {psw_d, b_d, acc_d} = 24'(merge(
          {8'h00, psw_q, b_q, acc_q}, wr_data, wr_strb));
        `REG_PCDP: {data_pointer_16_d, pc_d} = merge({data_pointer_16_q, pc_q}, wr_data, wr_strb);
        `REG_RAMA: {sp_d, rama_d} = 16'(merge({16'h0000, sp_q, rama_q},
          wr_data, wr_strb));
        `REG_RAMD: if (wr_strb[0]) begin
          gw_en = 1'b1;
          gw_addr = rama_q;
          gw_data = wr_data[7:0];
        end
        `REG_BITQ: if (wr_strb[0]) bitq_d = wr_data[7:0];
        default: ;
      endcase
    end
    if (busy) cnt_d = cnt_q - 16'h0001;
    if (commit) begin
      st_d = accum_alu_pkg::ST_IDLE;
      done_d = 1'b1;
      ill_d = kind == accum_alu_pkg::K_ILL;
      cyc_last_d = cyc;
      len_last_d = len;
      pc_d = pc_next;
      case (kind)
        accum_alu_pkg::K_ADD, accum_alu_pkg::K_ADD_WITH_CARRY,
        accum_alu_pkg::K_SUBTRACT_WITH_BORROW: begin
          if (kind == accum_alu_pkg::K_SUBTRACT_WITH_BORROW) begin // [RL13]
            s9 = {1'b0, acc_q} - {1'b0, src} - {8'h00, psw_q[7]};
            n5 = {1'b0, acc_q[3:0]} - {1'b0, src[3:0]} - {4'h0, psw_q[7]};
            psw_d[2] = (acc_q[7] ^ src[7]) & (s9[7] ^ acc_q[7]);
          end else begin // [RL11] [RL12]
            s9 = {1'b0, acc_q} + {1'b0, src} +
              {8'h00, kind == accum_alu_pkg::K_ADD_WITH_CARRY && psw_q[7]};
            n5 = {1'b0, acc_q[3:0]} + {1'b0, src[3:0]} +
              {4'h0, kind == accum_alu_pkg::K_ADD_WITH_CARRY && psw_q[7]};
            psw_d[2] = (acc_q[7] ~^ src[7]) & (s9[7] ^ acc_q[7]);
          end
          acc_d = s9[7:0];
          psw_d[7] = s9[8];
          psw_d[6] = n5[4];
        end
        accum_alu_pkg::K_MUL: begin // [RL14]
          {b_d, acc_d} = prod;
          psw_d[7] = 1'b0;
          psw_d[2] = |prod[15:8];
        end
        accum_alu_pkg::K_DIV: begin // [RL15]
          psw_d[7] = 1'b0;
          psw_d[2] = b_q == 8'h00;
          if (b_q != 8'h00) begin
            acc_d = acc_q / b_q;
            b_d = acc_q % b_q;
          end
        end
        accum_alu_pkg::K_DA: begin // [RL20]
          da9 = {1'b0, acc_q};
          if (acc_q[3:0] > `BCD_MAX || psw_q[6]) da9 = da9 + 9'h006;
          if (da9[7:4] > `BCD_MAX || da9[8] || psw_q[7]) begin
            da9 = da9 + 9'h060;
          end
          acc_d = da9[7:0];
          psw_d[7] = psw_q[7] | da9[8];
        end
        accum_alu_pkg::K_CLR: acc_d = 8'h00;
        accum_alu_pkg::K_CPL: acc_d = ~acc_q;
        accum_alu_pkg::K_AND, accum_alu_pkg::K_OR,
        accum_alu_pkg::K_XOR: begin
          res = kind == accum_alu_pkg::K_AND ? a_in & b_in :
            kind == accum_alu_pkg::K_OR ? a_in | b_in : a_in ^ b_in;
          if (to_dir) begin // [RL2]
            gw_en = 1'b1;
            gw_sfr = op1 >= `SFR_BASE;
            gw_addr = op1;
            gw_data = res;
          end else begin
            acc_d = res;
          end
        end
        accum_alu_pkg::K_INC, accum_alu_pkg::K_DEC: begin // [RL19]
          res = kind == accum_alu_pkg::K_INC ? src + 8'h01 : src - 8'h01;
          gw_en = 1'b1;
          gw_data = res;
          case (mode)
            accum_alu_pkg::M_DIR: begin
              gw_sfr = op1 >= `SFR_BASE;
              gw_addr = op1;
            end
            accum_alu_pkg::M_IND: gw_addr = ri;
            accum_alu_pkg::M_REG: gw_addr = reg_a;
            default: begin
              gw_sfr = 1'b1;
              gw_addr = `SFR_ACC;
            end
          endcase
        end
        accum_alu_pkg::K_INCDP: data_pointer_16_d = data_pointer_16_q + 16'h0001;
        accum_alu_pkg::K_SHORT_BRANCH:
          pc_d = pc_next + {{8{op1[7]}}, op1}; // [RL4]
        accum_alu_pkg::K_PAGE_JUMP, accum_alu_pkg::K_PAGE_CALL:
          pc_d = {pc_next[15:11], op[7:5], op1}; // [RL6] [RL8]
        accum_alu_pkg::K_FAR_JUMP, accum_alu_pkg::K_FAR_CALL:
          pc_d = {op1, op2}; // [RL7]
        accum_alu_pkg::K_MOVC: begin
          // Code byte arrives from fetch in the operand field
          fetch_d = (op[4] ? data_pointer_16_q : pc_next) + {8'h00, acc_q}; // [RL8]
          acc_d = op1;
        end
        default: ;
      endcase
      if (kind == accum_alu_pkg::K_PAGE_CALL || kind == accum_alu_pkg::K_FAR_CALL)
      begin
        gw_en = 1'b1;
        gw_addr = sp_q + 8'h01;
        gw_data = pc_next[7:0];
        gb_en = 1'b1;
        gb_addr = sp_q + 8'h02;
        gb_data = pc_next[15:8];
        sp_d = sp_q + 8'h02;
      end
    end
    ga_en = gw_en && !gw_sfr;
    ga_addr = gw_addr;
    ga_data = gw_data;
    if (gw_en && gw_sfr) begin
      case (gw_addr)
        `SFR_ACC: acc_d = gw_data;
        `SFR_B: b_d = gw_data;
        `SFR_PSW: psw_d = gw_data;
        `SFR_SP: sp_d = gw_data;
        `SFR_DPL: data_pointer_16_d[7:0] = gw_data;
        `SFR_DPH: data_pointer_16_d[15:8] = gw_data;
        default: ;
      endcase
    end
    // Completion outranks a same-cycle clear
    if (commit) done_d = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= accum_alu_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      instr_q <= 24'h000000;
      acc_q <= 8'h00;
      b_q <= 8'h00;
      psw_q <= 8'h00;
      sp_q <= `SP_RST;
      pc_q <= 16'h0000;
      data_pointer_16_q <= 16'h0000;
      fetch_q <= 16'h0000;
      rama_q <= 8'h00;
      bitq_q <= 8'h00;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      cyc_last_q <= 4'h0;
      len_last_q <= 2'd0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      instr_q <= instr_d;
      acc_q <= acc_d;
      b_q <= b_d;
      psw_q <= psw_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      data_pointer_16_q <= data_pointer_16_d;
      fetch_q <= fetch_d;
      rama_q <= rama_d;
      bitq_q <= bitq_d;
      done_q <= done_d;
      ill_q <= ill_d;
      cyc_last_q <= cyc_last_d;
      len_last_q <= len_last_d;
    end
  end

  // Internal RAM holds no reset; software must initialise it
  always_ff @(posedge mclk) begin
    if (ga_en) ram[ga_addr] <= ga_data;
    if (gb_en) ram[gb_addr] <= gb_data;
  end

  // AXI4-Lite slave; state writes refused while an opcode runs
  always_comb begin
    awr_d = awr_q;
    wr_d = wr_q;
    arr_d = arr_q;
    bv_d = bv_q;
    rv_d = rv_q;
    br_d = br_q;
    rr_d = rr_q;
    rd_d = rd_q;
    aw_got_d = aw_got_q | (s_axi_awvalid & awr_q);
    w_got_d = w_got_q | (s_axi_wvalid & wr_q);
    awa_d = (s_axi_awvalid & awr_q) ? s_axi_awaddr : awa_q;
    wd_d = (s_axi_wvalid & wr_q) ? s_axi_wdata : wd_q;
    ws_d = (s_axi_wvalid & wr_q) ? s_axi_wstrb : ws_q;
    wr_a = 8'(awa_d);
    wr_data = wd_d;
    wr_strb = ws_d;
    wr_ok = reg_hit(wr_a) && !busy;
    wr_go = aw_got_d && w_got_d && !bv_q;
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (wr_go) begin
      bv_d = 1'b1;
      br_d = wr_ok ? `RESP_OK : `RESP_ERR;
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
    end
    awr_d = !aw_got_d && !bv_d;
    wr_d = !w_got_d && !bv_d;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (s_axi_arvalid && arr_q) begin
      rv_d = 1'b1;
      rr_d = reg_hit(8'(s_axi_araddr)) ? `RESP_OK : `RESP_ERR;
      case (8'(s_axi_araddr))
        `REG_CTRL: rd_d = {31'h00000000, busy};
        `REG_INSTR: rd_d = {8'h00, instr_q};
        `REG_STAT: rd_d = {16'h0000, 4'h0, cyc_last_q, 2'b00, len_last_q,
          1'b0, ill_q, done_q, busy};
        `REG_ACCB: rd_d = {8'h00, psw_rd, b_q, acc_q};
        `REG_PCDP: rd_d = {data_pointer_16_q, pc_q};
        `REG_RAMA: rd_d = {16'h0000, sp_q, rama_q};
        `REG_RAMD: rd_d = {24'h000000, ram[rama_q]};
        `REG_BITQ: rd_d = {13'h0000, bitq_q[2:0], bm_byte, bitq_q};
        `REG_FETCH: rd_d = {16'h0000, fetch_q};
        default: rd_d = 32'h00000000;
      endcase
    end
    arr_d = !rv_d;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      arr_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      br_q <= `RESP_OK;
      rr_q <= `RESP_OK;
      rd_q <= 32'h00000000;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awa_q <= '0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      awr_q <= awr_d;
      wr_q <= wr_d;
      arr_q <= arr_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      br_q <= br_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rd_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_add;
    commit && kind == accum_alu_pkg::K_ADD |=>
      acc_q == 8'($past(acc_q) + $past(src));
  endproperty
  a_add: assert property (p_add) else $error("add result wrong"); // [RL11]
  property p_subtract_with_borrow;
    commit && kind == accum_alu_pkg::K_SUBTRACT_WITH_BORROW && !psw_q[7] |=>
      psw_q[7] == ($past(acc_q) < $past(src));
  endproperty
  a_subtract_with_borrow: assert property (p_subtract_with_borrow) else $error("borrow wrong"); // [RL13]
  property p_mul;
    commit && kind == accum_alu_pkg::K_MUL |=> !psw_q[7] &&
      {b_q, acc_q} == 16'($past(acc_q) * $past(b_q));
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong"); // [RL14]
  property p_div;
    commit && kind == accum_alu_pkg::K_DIV && b_q != 8'h00 |=>
      acc_q == $past(acc_q) / $past(b_q) && !psw_q[7] && !psw_q[2];
  endproperty
  a_div: assert property (p_div) else $error("quotient wrong"); // [RL15]
  property p_short_branch;
    commit && kind == accum_alu_pkg::K_SHORT_BRANCH |=>
      pc_q == 16'($past(pc_next) + {{8{$past(op1[7])}}, $past(op1)});
  endproperty
  a_short_branch: assert property (p_short_branch) else $error("short branch wrong"); // [RL4]
  property p_page;
    commit && kind == accum_alu_pkg::K_PAGE_JUMP |=>
      pc_q[15:11] == $past(pc_next[15:11]) && pc_q[7:0] == $past(op1);
  endproperty
  a_page: assert property (p_page) else $error("page jump wrong"); // [RL6]
  property p_far;
    commit && kind == accum_alu_pkg::K_FAR_JUMP |=>
      pc_q == {$past(op1), $past(op2)};
  endproperty
  a_far: assert property (p_far) else $error("far jump wrong"); // [RL7]
  property p_logic_flags;
    commit && kind == accum_alu_pkg::K_XOR && !to_dir |=>
      psw_q == $past(psw_q);
  endproperty
  a_logic_flags: assert property (p_logic_flags) // [RL18]
    else $error("logic op touched flags");
  property p_mul_time;
    $rose(busy) && kind == accum_alu_pkg::K_MUL |->
      (busy && !commit) [*8] ##0 cnt_q == 16'(`CYC_MULDIV * CLKS_PER_ICYC - 7);
  endproperty
  a_mul_time: assert property (p_mul_time) // [RL10]
    else $error("multiply timing wrong");
  property p_clr;
    commit && kind == accum_alu_pkg::K_CLR |=> acc_q == 8'h00 && !ill_q;
  endproperty
  a_clr: assert property (p_clr) else $error("clear wrong"); // [RL20]
  c_add: cover property (commit && kind == accum_alu_pkg::K_ADD_WITH_CARRY);
  c_call: cover property (commit && kind == accum_alu_pkg::K_FAR_CALL);
  c_dir: cover property (commit && to_dir);
endmodule : accum_alu_instr_decode

// ### tb/tb.sv
// Self-checking bench for the accumulator decode block.
// Assumes the block is reached only through its AXI4-Lite port.
`include "accum_alu_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [65:0] e;
  logic [31:0] got;
  logic [7:0] ra, rb;
  logic [15:0] pr;
  int n_mismatch = 0, checks_done = 0, seed = 90;

  always #5 mclk = ~mclk;

  accum_alu_instr_decode #(.CLKS_PER_ICYC(4)) dut (.mclk(mclk),
    .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic hang;
    n_mismatch++;
    $display("FAIL %0t handshake timeout", $time);
    conclude();
  endtask : hang

  // Zero mask marks a poll read whose data is not judged
  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      if (e[63:32] != 32'h0) begin
        chk(s_axi_rdata & e[63:32], e[31:0]);
        chk({30'h0, s_axi_rresp}, {30'h0, e[65:64]});
      end
    end
    if (s_axi_bvalid && s_axi_bready)
      chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit done;
    done = 1'b0;
    bq.push_back(r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge mclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
      done = s_axi_bvalid;
    end
    s_axi_bready <= 1'h0;
    if (!done) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x, input logic [1:0] r);
    bit done;
    done = 1'b0;
    rq.push_back({r, m, x & m});
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge mclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
      done = s_axi_rvalid;
      got = s_axi_rdata;
    end
    s_axi_rready <= 1'h0;
    if (!done) hang();
  endtask : rd

  // Loads A/B/status, runs one opcode, checks status and result
  task automatic run(input logic [23:0] ins, input logic [7:0] a, b, p,
                     input logic [7:0] ea, eb, ep, input logic [11:0] es);
    wr(`REG_ACCB, {8'h00, p, b, a}, `RESP_OK);
    wr(`REG_INSTR, {8'h00, ins}, `RESP_OK);
    wr(`REG_CTRL, 32'h1, `RESP_OK);
    wr(`REG_INSTR, 32'h0, `RESP_ERR);
    got = 32'h0;
    for (int i = 0; i < 60 && got[1] !== 1'h1; i++)
      rd(`REG_STAT, 32'h0, 32'h0, `RESP_OK);
    if (got[1] !== 1'h1) hang();
    rd(`REG_STAT, 32'hF37, {20'h0, es}, `RESP_OK);
    rd(`REG_ACCB, 32'hFFFFFF, {8'h00, ep | {7'h0, ^ea}, eb, ea},
       `RESP_OK);
    wr(`REG_STAT, 32'h2, `RESP_OK);
    $display("test opcode %h done", ins[7:0]);
  endtask : run

  // Presets PC, runs a branch with A/B/status at zero, checks new PC
  task automatic br(input logic [23:0] ins, input logic [15:0] pc, t,
                    input logic [11:0] es);
    wr(`REG_PCDP, {16'h0, pc}, `RESP_OK);
    run(ins, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, es);
    rd(`REG_PCDP, 32'hFFFF, {16'h0, t}, `RESP_OK);
  endtask : br

  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    rd(`REG_RAMA, 32'hFFFF, 32'h0700, `RESP_OK);
    rd(`REG_ACCB, 32'hFFFFFF, 32'h0, `RESP_OK);
    rd(8'h24, 32'hFFFFFFFF, 32'h0, `RESP_ERR);
    wr(8'h24, 32'h1, `RESP_ERR);
    wr(`REG_RAMA, 32'h0B, `RESP_OK);
    wr(`REG_RAMD, 32'h11, `RESP_OK);
    wr(`REG_RAMA, 32'h09, `RESP_OK);
    wr(`REG_RAMD, 32'h0B, `RESP_OK);
    s_axi_wstrb <= 4'h2;
    wr(`REG_RAMA, 32'h4000, `RESP_OK);
    s_axi_wstrb <= 4'hF;
    rd(`REG_RAMA, 32'hFFFF, 32'h4009, `RESP_OK);
    wr(`REG_BITQ, 32'h1D, `RESP_OK);
    rd(`REG_BITQ, 32'h7FFFF, 32'h5231D, `RESP_OK);
    wr(`REG_BITQ, 32'hE3, `RESP_OK);
    rd(`REG_BITQ, 32'h7FFFF, 32'h3E0E3, `RESP_OK);
    $display("test bus and reset done");
    run(24'h000124, 8'h7F, 8'h0, 8'h0, 8'h80, 8'h0, 8'h44, 12'h222);
    run(24'h000034, 8'hFF, 8'h0, 8'h80, 8'h0, 8'h0, 8'hC0, 12'h222);
    run(24'h000194, 8'h0, 8'h0, 8'h0, 8'hFF, 8'h0, 8'hC0, 12'h222);
    run(24'h00002B, 8'h22, 8'h0, 8'h08, 8'h33, 8'h0, 8'h08, 12'h112);
    run(24'h000027, 8'h01, 8'h0, 8'h08, 8'h12, 8'h0, 8'h08, 12'h112);
    run(24'h003C54, 8'hF0, 8'h0, 8'h44, 8'h30, 8'h0, 8'h44, 12'h222);
    run(24'h008044, 8'h01, 8'h0, 8'h80, 8'h81, 8'h0, 8'h80, 12'h222);
    run(24'h00FF64, 8'h5A, 8'h0, 8'hC4, 8'hA5, 8'h0, 8'hC4, 12'h222);
    run(24'h00F042, 8'h0C, 8'h30, 8'h0, 8'h0C, 8'h3C, 8'h0, 12'h222);
    run(24'h000004, 8'hFF, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 12'h112);
    run(24'h0000F4, 8'h0F, 8'h0, 8'h0, 8'hF0, 8'h0, 8'h0, 12'h112);
    run(24'h0000E4, 8'h5A, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 12'h112);
    run(24'h0000D4, 8'h9A, 8'h0, 8'h0, 8'h0, 8'h0, 8'h80, 12'h112);
    run(24'h0000A5, 8'h3C, 8'h0, 8'h0, 8'h3C, 8'h0, 8'h0, 12'h116);
    br(24'h00F080, 16'h1234, 16'h1226, 12'h322);
    br(24'h0023A1, 16'h17FE, 16'h1D23, 12'h322);
    br(24'h563402, 16'h0100, 16'h3456, 12'h432);
    repeat (4) begin
      ra = 8'($random(seed));
      rb = 8'($random(seed)) | 8'h01;
      pr = ra * rb;
      run(24'hA4, ra, rb, 8'h80, pr[7:0], pr[15:8],
          {5'h0, pr[15:8] != 8'h0, 2'h0}, 12'h512);
      run(24'h84, ra, rb, 8'hC4, ra / rb, ra % rb, 8'h40, 12'h512);
    end
    conclude();
  end
endmodule : tb
